// ==== csd_chk_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module csd_chk
   import csd_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire csd_cyc_t    cyc_i,
   input wire logic [15:0] prog_select_ctrl_o,
   input wire logic [7:0]  intc_base_reloc_o,
   input wire logic        prog_sel_n_o,
   input wire logic        intc_sel_n_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Masked bits drop out of the compare; mode 10 never hits
   sequence s_io_hit;
      cyc_i.active && cyc_i.is_io && cyc_i.subtractive && !cyc_i.isa_master
      && cyc_i.addr[31:4] == {16'h0000, prog_select_ctrl_o[15:4]} && prog_select_ctrl_o[1:0] != 2'h2
      && ((cyc_i.addr[3:2] ^ prog_select_ctrl_o[3:2]) & ~prog_select_ctrl_o[1:0]) == 2'h0;
   endsequence
   AST_PROG_HIT: assert property (s_io_hit |=> !prog_sel_n_o) else $error("missed hit");
   AST_PROG_CMD: assert property (!prog_sel_n_o |-> $past(cyc_i.active && cyc_i.is_io && cyc_i.subtractive
      && !cyc_i.isa_master)) else $error("bad command");
   AST_PROG_UP: assert property (!prog_sel_n_o |-> $past(cyc_i.addr[31:16]) == 16'h0000) else $error("upper");
   AST_PROG_ADR: assert property (!prog_sel_n_o |-> $past(cyc_i.addr[15:4])
      == $past(prog_select_ctrl_o[15:4])) else $error("prog addr");
   AST_PROG_OFF: assert property (!prog_sel_n_o |-> $past(prog_select_ctrl_o[1:0]) != 2'h2) else $error("off");
   AST_INTC_X: assert property (!intc_sel_n_o |-> $past(cyc_i.addr[31:13])
      == {16'hFEC0, $past(intc_base_reloc_o[5:3])}) else $error("intc x");
   AST_INTC_Y: assert property (!intc_sel_n_o |-> $past(cyc_i.addr[11:10])
      == $past(intc_base_reloc_o[1:0])) else $error("intc y");
   AST_INTC_DUAL: assert property (!intc_sel_n_o && !$past(intc_base_reloc_o[6]) |-> $past(cyc_i.addr[12])
      == $past(intc_base_reloc_o[2])) else $error("intc a12");
   AST_STAND: assert property (!$past(cyc_i.active) |-> prog_sel_n_o && intc_sel_n_o) else $error("idle");
   // Both slots answer; a dual range leaves address bit 12 free
   sequence s_intc_hit;
      cyc_i.active && cyc_i.is_mem && !cyc_i.isa_master && cyc_i.addr[31:16] == 16'hFEC0
      && cyc_i.addr[9:5] == 5'h00 && cyc_i.addr[3:2] == 2'h0 && cyc_i.addr[11:10] == intc_base_reloc_o[1:0]
      && ((cyc_i.addr[15:12] ^ intc_base_reloc_o[5:2]) & ~{3'h0, intc_base_reloc_o[6]}) == 4'h0;
   endsequence
   AST_INTC_HIT: assert property (s_intc_hit |=> !intc_sel_n_o) else $error("missed intc hit");
endmodule
bind csd_top csd_chk i_chk (.core_clk_i, .rst_i, .cyc_i, .prog_select_ctrl_o, .intc_base_reloc_o,
   .prog_sel_n_o, .intc_sel_n_o);
`default_nettype wire

// ==== csd_match.sv ====
`timescale 1ns/10ps
`default_nettype none
// Masked equality compare: a bit whose mask is set is a don't care
module csd_match #(
   parameter int W = 4
) (
   input  wire logic [W-1:0] addr_i,
   input  wire logic [W-1:0] ref_i,
   input  wire logic [W-1:0] mask_i,
   output logic              match_o
);

   logic [W-1:0] hit;

   // Elaboration check on the width
   generate
      if (W < 1)
      begin : g_bad_width
         $error("csd_match needs W of at least 1");
      end
   endgenerate

   // One compare per address bit
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         assign hit[i] = mask_i[i] | (addr_i[i] == ref_i[i]);
      end
   endgenerate

   assign match_o = &hit;

endmodule
`default_nettype wire

// ==== csd_pci_mst.sv ====
`timescale 1ns/10ps
`default_nettype none
module csd_pci_mst (
   input wire logic                 core_clk_i,
   output var csd_pkg::csd_cyc_t    cyc_o
);
   import csd_pkg::*;
   initial cyc_o = '0;
   // One-cycle cycle; released address shows its inverse, never the old value
   task automatic run(input logic [3:0] f, input logic [31:0] a);
      @(posedge core_clk_i);
      #1 cyc_o = {1'b1, f, a};
      @(posedge core_clk_i);
      #1 cyc_o = {5'h00, ~a};
   endtask
endmodule
`default_nettype wire

// ==== csd_pkg.sv ====
`default_nettype none
package csd_pkg;

   // Configuration space offsets (byte addresses, dword aligned)
   localparam logic [7:0]  CSD_OFS_PROG_CTRL   = 8'h78;
   localparam logic [7:0]  CSD_OFS_INTC_RELOC  = 8'h80;

   // Reset values
   localparam logic [15:0] CSD_PROG_CTRL_RST   = 16'h0002;
   localparam logic [7:0]  CSD_INTC_RELOC_RST  = 8'h00;

   // Programmable select control fields
   localparam int          CSD_PCTL_ADDR_LSB   = 2;
   localparam int          CSD_PCTL_ADDR_MSB   = 15;
   localparam int          CSD_PCTL_MASK3_BIT  = 1;
   localparam int          CSD_PCTL_MASK2_BIT  = 0;
   localparam logic [1:0]  CSD_PCTL_MODE_OFF   = 2'h2;

   // Relocation register fields
   localparam int          CSD_RLC_DUAL_BIT    = 6;
   localparam int          CSD_RLC_X_LSB       = 2;
   localparam int          CSD_RLC_X_MSB       = 5;
   localparam int          CSD_RLC_Y_LSB       = 0;
   localparam int          CSD_RLC_Y_MSB       = 1;
   localparam logic [7:0]  CSD_RLC_WR_MASK     = 8'h7F;

   // Address fields used by the decoders
   localparam int          CSD_IO_ADDR_W       = 16;
   localparam logic [15:0] CSD_IO_UPPER_ZERO   = 16'h0000;
   localparam logic [15:0] CSD_INTC_PAGE       = 16'hFEC0;
   localparam int          CSD_INTC_X_ADDR_LSB = 12;
   localparam int          CSD_INTC_Y_ADDR_LSB = 10;
   localparam int          CSD_INTC_SLOT_BIT   = 4;

   // Cycle presented by the bridge's PCI target logic
   typedef struct packed {
      logic        active;      // Cycle in progress, held for its length
      logic        is_io;       // I/O command
      logic        is_mem;      // Memory command
      logic        subtractive; // Claimed by subtractive decode
      logic        isa_master;  // Cycle comes from an ISA master
      logic [31:0] addr;        // Cycle address
   } csd_cyc_t;

   // Configuration access from the function's config space logic
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } csd_cfg_req_t;

endpackage
`default_nettype wire

// ==== csd_top.sv ====
`timescale 1ns/10ps
`default_nettype none
//Contract
// - Program select only for subtractive PCI I/O hits
// - Window anywhere in 16-bit I/O, 4/8/16 bytes
// - Program select needs address bits 31:16 zero
// - Never program select for ISA master cycles
// - Control bits 15:2 hold compare address
// - Bit1 masks address bit3, bit0 masks bit2
// - Mask 00=4, 01=8, 10=off, 11=16 bytes
// - Only one contiguous window, split range refused
// - Intc select at base+00h and base+10h
// - Relocation bits 5:2 compare address 15:12
// - Relocation bits 1:0 compare address 11:10
// - Relocation bit6 ignores address bit 12
// - Reset relocation zero decodes lowest base
module csd_top (
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire csd_pkg::csd_cyc_t     cyc_i,
   input  wire csd_pkg::csd_cfg_req_t cfg_i,
   output logic [31:0]                cfg_rdata_o,
   output logic [15:0]                prog_select_ctrl_o,
   output logic [7:0]                 intc_base_reloc_o,
   output logic                       prog_sel_n_o,
   output logic                       intc_sel_n_o
);
   import csd_pkg::*;

   // Compare widths follow the register field layouts
   localparam int IO_CMP_W   = CSD_PCTL_ADDR_MSB - CSD_PCTL_ADDR_LSB + 1;
   localparam int INTC_CMP_W = CSD_RLC_X_MSB - CSD_RLC_Y_LSB + 1;

   logic [15:0] prog_ctrl_q;
   logic [15:0] prog_ctrl_d;
   logic [7:0]  reloc_q;
   logic [7:0]  reloc_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        prog_sel_n_q;
   logic        prog_sel_n_d;
   logic        intc_sel_n_q;
   logic        intc_sel_n_d;

   logic [13:0] io_match_addr;
   logic [13:0] io_mask;
   logic        io_addr_hit;
   logic        prog_enable;
   logic        prog_hit;

   logic [5:0]  intc_ref;
   logic [5:0]  intc_mask;
   logic        intc_base_hit;
   logic        intc_offset_hit;
   logic        intc_hit;
   logic        dual_range_enable;

   // The compare vectors below are sized for these layouts; refuse any other
   generate
      if (IO_CMP_W != 14)
      begin : g_bad_io_field
         $error("csd_top needs a 14-bit programmable address field");
      end
      if (INTC_CMP_W != 6)
      begin : g_bad_reloc_field
         $error("csd_top needs a 6-bit relocation base field");
      end
      if (CSD_INTC_X_ADDR_LSB - CSD_INTC_Y_ADDR_LSB != CSD_RLC_X_LSB - CSD_RLC_Y_LSB)
      begin : g_bad_intc_order
         $error("csd_top needs the y address bits directly below the x bits");
      end
      if (CSD_INTC_SLOT_BIT + 1 >= CSD_INTC_Y_ADDR_LSB)
      begin : g_bad_slot_bit
         $error("csd_top needs the slot bit below the y address bits");
      end
   endgenerate

   // Register writes honour the byte enables; reserved bit 7 is not stored
   // Byte lanes 3:2 carry nothing here, so their enables are ignored
   // A write to any other offset leaves both registers untouched
   always_comb
   begin
      prog_ctrl_d = prog_ctrl_q;
      reloc_d     = reloc_q;
      if (cfg_i.wr && cfg_i.addr == CSD_OFS_PROG_CTRL)
      begin
         if (cfg_i.be[0])
         begin
            prog_ctrl_d[7:0] = cfg_i.wdata[7:0];
         end
         if (cfg_i.be[1])
         begin
            prog_ctrl_d[15:8] = cfg_i.wdata[15:8];
         end
      end
      if (cfg_i.wr && cfg_i.addr == CSD_OFS_INTC_RELOC && cfg_i.be[0])
      begin
         reloc_d = cfg_i.wdata[7:0] & CSD_RLC_WR_MASK;
      end
   end

   // Read data is captured one cycle after the read strobe
   // A write in the same cycle is not yet visible, so the old value returns
   // Unmapped offsets read as zero rather than holding stale data
   always_comb
   begin
      rdata_d = rdata_q;
      if (cfg_i.rd)
      begin
         unique case (cfg_i.addr)
            CSD_OFS_PROG_CTRL:  rdata_d = {16'h0000, prog_ctrl_q};
            CSD_OFS_INTC_RELOC: rdata_d = {24'h000000, reloc_q};
            default:            rdata_d = 32'h00000000;
         endcase
      end
   end

   // Configuration state
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prog_ctrl_q <= CSD_PROG_CTRL_RST;
         reloc_q     <= CSD_INTC_RELOC_RST;
         rdata_q     <= 32'h00000000;
      end
      else
      begin
         prog_ctrl_q <= prog_ctrl_d;
         reloc_q     <= reloc_d;
         rdata_q     <= rdata_d;
      end
   end

   // Programmable window: base bits 15:2, with bits 3:2 optionally don't care
   // A masked bit widens the window to 8 or 16 contiguous bytes
   assign io_match_addr = prog_ctrl_q[CSD_PCTL_ADDR_MSB:CSD_PCTL_ADDR_LSB];
   assign io_mask = {12'h000,
                     prog_ctrl_q[CSD_PCTL_MASK3_BIT],
                     prog_ctrl_q[CSD_PCTL_MASK2_BIT]};

   csd_match #(
      .W(IO_CMP_W)
   ) u_io_match (
      .addr_i  (cyc_i.addr[CSD_IO_ADDR_W-1:CSD_PCTL_ADDR_LSB]),
      .ref_i   (io_match_addr),
      .mask_i  (io_mask),
      .match_o (io_addr_hit)
   );

   // Masking bit 3 alone would split the window, so that code means off
   assign prog_enable = (prog_ctrl_q[1:0] != CSD_PCTL_MODE_OFF);

   // Only subtractive I/O from PCI masters with a 16-bit address qualifies
   assign prog_hit = cyc_i.active
                   & cyc_i.is_io
                   & cyc_i.subtractive
                   & ~cyc_i.isa_master
                   & (cyc_i.addr[31:16] == CSD_IO_UPPER_ZERO)
                   & io_addr_hit
                   & prog_enable;

   // Interrupt controller base: x compares 15:12, y compares 11:10
   assign dual_range_enable = reloc_q[CSD_RLC_DUAL_BIT];
   assign intc_ref  = {reloc_q[CSD_RLC_X_MSB:CSD_RLC_X_LSB],
                       reloc_q[CSD_RLC_Y_MSB:CSD_RLC_Y_LSB]};
   assign intc_mask = {3'h0, dual_range_enable, 2'h0};

   csd_match #(
      .W(INTC_CMP_W)
   ) u_intc_match (
      .addr_i  (cyc_i.addr[CSD_INTC_X_ADDR_LSB+3:CSD_INTC_Y_ADDR_LSB]),
      .ref_i   (intc_ref),
      .mask_i  (intc_mask),
      .match_o (intc_base_hit)
   );

   // Only the two dword slots at +00h and +10h answer; bit 4 picks the slot
   assign intc_offset_hit = (cyc_i.addr[CSD_INTC_Y_ADDR_LSB-1:CSD_INTC_SLOT_BIT+1] == 5'h00)
                          & (cyc_i.addr[CSD_INTC_SLOT_BIT-1:2] == 2'h0);

   // Board logic splits a dual range with ISA address bit 12
   // The select itself cannot tell the two controllers apart
   assign intc_hit = cyc_i.active
                   & cyc_i.is_mem
                   & ~cyc_i.isa_master
                   & (cyc_i.addr[31:16] == CSD_INTC_PAGE)
                   & intc_base_hit
                   & intc_offset_hit;

   // Selects are active low and follow the cycle one clock later
   // Registering them costs a clock but keeps the pins free of decode glitches
   always_comb
   begin
      prog_sel_n_d = ~prog_hit;
      intc_sel_n_d = ~intc_hit;
   end

   // Select outputs idle high through reset
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prog_sel_n_q <= 1'b1;
         intc_sel_n_q <= 1'b1;
      end
      else
      begin
         prog_sel_n_q <= prog_sel_n_d;
         intc_sel_n_q <= intc_sel_n_d;
      end
   end

   assign cfg_rdata_o        = rdata_q;
   assign prog_select_ctrl_o = prog_ctrl_q;
   assign intc_base_reloc_o  = reloc_q;
   assign prog_sel_n_o       = prog_sel_n_q;
   assign intc_sel_n_o       = intc_sel_n_q;

endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
   import csd_pkg::*;
   logic         core_clk_i;
   logic         rst_i;
   csd_cyc_t     cyc;
   csd_cfg_req_t cfg;
   logic [31:0]  rdata;
   logic [15:0]  pctl;
   logic [7:0]   rlc;
   logic         psel_n;
   logic         isel_n;
   logic [31:0]  seed = 32'h0001_486B;
   int           num_errors = 0;
   int           tests_run = 0;
   int           ctl = 2;
   int           rl = 0;
   csd_pci_mst i_mst (.core_clk_i(core_clk_i), .cyc_o(cyc));
   csd_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cyc_i(cyc), .cfg_i(cfg), .cfg_rdata_o(rdata),
      .prog_select_ctrl_o(pctl), .intc_base_reloc_o(rlc), .prog_sel_n_o(psel_n), .intc_sel_n_o(isel_n));
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Reference decoders kept in integer form, separate from the design's style
   function automatic logic ep(input logic [3:0] f, input int a);
      return !(f[3] && f[1] && !f[0] && (ctl & 3) != 2 && (a >> 16) == 0
         && ((a ^ ctl) & 'hFFFC & ~((ctl & 3) << 2)) == 0);
   endfunction
   function automatic logic ei(input logic [3:0] f, input int a);
      return !(f[2] && !f[0] && (a >> 16) == 'hFEC0 && (a & 'h3EC) == 0
         && (((a >> 10) ^ rl) & ((rl & 64) != 0 ? 'h3B : 'h3F)) == 0);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // Register and select values that every reset must leave behind
   task automatic rst_chk();
      chk("ctrl", 16'h0002, pctl);
      chk("reloc", 8'h00, rlc);
      chk("prog_sel_n", 1, psel_n);
      chk("intc_sel_n", 1, isel_n);
   endtask
   task automatic cf(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      #1 cfg = {w, ~w, a, 4'hF, d};
      @(posedge core_clk_i);
      #1 cfg = '0;
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Free-running clock
   initial
   begin
      core_clk_i = 0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   // Reset, register checks, then random decode traffic
   initial
   begin
      logic [31:0] a;
      logic [3:0]  f;
      rst_i = 1;
      cfg = '0;
      repeat (16) @(posedge core_clk_i);
      #1 rst_i = 0;
      rst_chk();
      cf(0, 8'h78, 0);
      chk("rdata", 16'h0002, rdata);
      cf(0, 8'h84, 0);
      chk("rdata", 0, rdata);
      i_mst.run(4'h4, 32'hFEC0_0010);
      chk("intc_sel_n", 0, isel_n);
      $display("reset test done");
      for (int i = 0; i < 800; i++)
      begin
         if (i % 8 == 0)
         begin
            ctl = (rnd() & 'hFFFC) | (i / 8 % 4);
            cf(1, 8'h78, ctl);
            cf(0, 8'h78, 0);
            chk("ctrl", ctl, rdata);
            rl = rnd() & 'hFF;
            cf(1, 8'h80, rl);
            rl &= 'h7F;
            cf(0, 8'h80, 0);
            chk("reloc", rl, rdata);
         end
         a = rnd();
         f = 4'(rnd());
         if ((rnd() & 3) != 0)
            f = (i % 4 == 1) ? 4'h4 : 4'hA;
         case (i % 4)
            0: a[31:4] = 28'(ctl >> 4);
            1: a = {16'hFEC0, rl[5:0] ^ {3'h0, a[20] & a[21], 2'h0}, 5'h00, a[4], 2'h0, a[1:0]};
            2: a[15:4] = 12'(ctl >> 4);
            default: ;
         endcase
         i_mst.run(f, a);
         chk("prog_sel_n", ep(f, a), psel_n);
         chk("intc_sel_n", ei(f, a), isel_n);
      end
      $display("decode test done");
      // Second reset in mid-run must undo the programmed registers
      @(posedge core_clk_i);
      #1 rst_i = 1;
      #1;
      rst_chk();
      repeat (2) @(posedge core_clk_i);
      #1 rst_i = 0;
      i_mst.run(4'h4, 32'hFEC0_0000);
      chk("intc_sel_n", 0, isel_n);
      $display("reset again test done");
      summarize();
   end
endmodule
`default_nettype wire
